// ---- mao_ascii_out.sv ----
// Meter reading output: character-serial strobe port and async serial link
// Operation
// - A reading goes out as nine ASCII characters of seven bits with strobe.
// - Strobe falling edge marks character valid; receiver captures there.
// - Strobe port runs 25 chars/s with strap grounded, 100 chars/s open.
// - Serial link runs 300 baud with strap grounded, 1200 baud open.
// - Serial link sends async ASCII; loop current flowing is the mark state.
// - Logic-level serial output carries the same stream at same rate.
// - Open thermocouple sends plus sign and four E characters.
// - New readings for output are spaced at least 150 ms apart.
// - Request asserted during a transmission is ignored entirely.
// - Request never changes the displayed reading.
// - Trigger input current-on to current-off edge starts serial output.
// - Trigger edge during a transmission is discarded.
// - Trigger activity never changes the displayed reading.
// - After power-up, three seconds of test pattern before readings.
// - New conversion results arrive at two and a half per second.
// - Each conversion integrates over a 100 ms window.
`timescale 1ns/1ps
module mao_ascii_out #(
    parameter int unsigned TEST_CYC      = mao_pkg::TEST_CYC,
    parameter int unsigned CONV_CYC      = mao_pkg::CONV_CYC,
    parameter int unsigned INTEG_CYC     = mao_pkg::INTEG_CYC,
    parameter int unsigned GAP_CYC       = mao_pkg::GAP_CYC,
    parameter int unsigned SLOW_CHAR_CYC = mao_pkg::SLOW_CHAR_CYC,
    parameter int unsigned FAST_CHAR_CYC = mao_pkg::FAST_CHAR_CYC,
    parameter int unsigned SLOW_BIT_CYC  = mao_pkg::SLOW_BIT_CYC,
    parameter int unsigned FAST_BIT_CYC  = mao_pkg::FAST_BIT_CYC
) (
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    input  wire logic                  link_clk_in,
    input  wire logic                  rate_select_strap_in,
    input  wire logic                  request_n_in,
    input  wire logic                  serial_trig_in,
    input  wire mao_pkg::mao_reading_t reading_in,
    output logic [6:0]                 char_data_out,
    output logic                       char_strobe_out,
    output logic                       loop_current_out,
    output logic                       serial_ttl_out,
    output logic                       busy_out,
    output logic                       integrate_out,
    output logic                       new_data_out,
    output logic                       disp_test_out,
    output mao_pkg::mao_reading_t      disp_reading_out
);
    function automatic logic [6:0] mao_char(input logic [3:0] idx,
                                            input mao_pkg::mao_reading_t r);
        logic [3:0] dig;
        dig = 4'h0;
        case (idx)
            4'h1: dig = r.bcd[15:12];
            4'h2: dig = r.bcd[11:8];
            4'h3: dig = r.bcd[7:4];
            4'h4: dig = r.bcd[3:0];
            default: dig = 4'h0;
        endcase
        case (idx)
            4'h0: mao_char = (r.neg && !r.open_tc) ? mao_pkg::CH_MINUS : mao_pkg::CH_PLUS;
            4'h1, 4'h2, 4'h3, 4'h4:
                mao_char = r.open_tc ? mao_pkg::CH_E : (mao_pkg::CH_ZERO | {3'h0, dig});
            4'h5: mao_char = mao_pkg::CH_SPACE;
            4'h6: mao_char = r.fahr ? mao_pkg::CH_F : mao_pkg::CH_C;
            4'h7: mao_char = mao_pkg::CH_CR;
            default: mao_char = mao_pkg::CH_LF;
        endcase
    endfunction : mao_char
    // Pin synchronisers; ack toggle comes back from the link domain
    logic strap_s1_reg, strap_s2_reg, req_s1_reg, req_s2_reg;
    logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
    logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
    logic ack_tgl_reg;
    always_ff @(posedge clock_in) begin
        strap_s1_reg <= rate_select_strap_in;
        strap_s2_reg <= strap_s1_reg;
        req_s1_reg   <= request_n_in;
        req_s2_reg   <= req_s1_reg;
        trig_s1_reg  <= serial_trig_in;
        trig_s2_reg  <= trig_s1_reg;
        trig_s3_reg  <= trig_s2_reg;
        ack_s1_reg   <= ack_tgl_reg;
        ack_s2_reg   <= ack_s1_reg;
        ack_s3_reg   <= ack_s2_reg;
    end
    logic [31:0] test_cnt_reg, conv_cnt_reg, gap_cnt_reg;
    logic        disp_test_reg, integ_reg, new_data_reg;
    mao_pkg::mao_reading_t result_reg;
    wire         test_on  = (test_cnt_reg != 32'h0);
    wire         conv_end = (conv_cnt_reg == 32'h0);
    // Update held back until the spacing guard has expired
    wire         gap_ok   = (gap_cnt_reg >= 32'(GAP_CYC - 1));
    wire         update   = conv_end && gap_ok;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            test_cnt_reg  <= 32'(TEST_CYC - 1);
            disp_test_reg <= 1'b1;
        end else begin
            test_cnt_reg  <= test_on ? test_cnt_reg - 32'h1 : test_cnt_reg;
            disp_test_reg <= test_on;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            // Reset at period end so the first window runs full length
            conv_cnt_reg <= 32'h0;
            gap_cnt_reg  <= 32'h0;
            integ_reg    <= 1'b0;
            new_data_reg <= 1'b0;
        end else begin
            conv_cnt_reg <= conv_end ? 32'(CONV_CYC - 1) : conv_cnt_reg - 32'h1;
            gap_cnt_reg  <= update ? 32'h0 : (gap_ok ? gap_cnt_reg : gap_cnt_reg + 32'h1);
            integ_reg    <= conv_end || (conv_cnt_reg > 32'(CONV_CYC - INTEG_CYC));
            new_data_reg <= update;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            result_reg <= mao_pkg::READING_RST;
        end else if (update) begin
            result_reg <= reading_in;
        end
    end

    mao_pkg::mao_state_t state_reg;
    logic [3:0]  idx_reg;
    logic [31:0] cnt_reg;
    logic [6:0]  data_reg, ser_char_reg;
    logic        strobe_reg, req_tgl_reg, armed_reg;
    mao_pkg::mao_reading_t tx_reading_reg;

    wire         idle     = (state_reg == mao_pkg::ST_IDLE);
    wire  [31:0] char_per = strap_s2_reg ? 32'(FAST_CHAR_CYC) : 32'(SLOW_CHAR_CYC);
    wire  [31:0] half_per = char_per >> 1;
    wire         last     = (idx_reg == mao_pkg::LAST_CHAR);
    wire         ack_edge = (ack_s3_reg != ack_s2_reg);
    // request recognised only when idle and freshly low
    wire         req_go   = idle && !test_on && armed_reg && !req_s2_reg;
    wire         trig_go  = idle && !test_on && !req_go && trig_s3_reg && !trig_s2_reg;
    wire  [6:0]  next_chr = mao_char(idx_reg + 4'h1, tx_reading_reg);

    // Arm only while idle so a low raised mid-transmission never counts
    always_ff @(posedge clock_in) begin
        if (rst_in || req_go) begin
            armed_reg <= 1'b0;
        end else if (req_s2_reg && idle) begin
            armed_reg <= 1'b1;
        end else if (!req_s2_reg && !idle) begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg      <= mao_pkg::ST_IDLE;
            idx_reg        <= 4'h0;
            cnt_reg        <= 32'h0;
            data_reg       <= 7'h00;
            strobe_reg     <= 1'b0;
            ser_char_reg   <= 7'h00;
            req_tgl_reg    <= 1'b0;
            tx_reading_reg <= mao_pkg::READING_RST;
        end else begin
            case (state_reg)
                mao_pkg::ST_IDLE: begin
                    idx_reg        <= 4'h0;
                    tx_reading_reg <= result_reg;
                    if (req_go) begin
                        data_reg   <= mao_char(4'h0, result_reg);
                        strobe_reg <= 1'b1;
                        cnt_reg    <= char_per - 32'h1;
                        state_reg  <= mao_pkg::ST_CHAR;
                    end else if (trig_go) begin
                        state_reg <= mao_pkg::ST_SER;
                    end
                end
                // data changes only on the edge that raises strobe
                mao_pkg::ST_CHAR: begin
                    cnt_reg <= cnt_reg - 32'h1;
                    if (cnt_reg == half_per) begin
                        strobe_reg <= 1'b0;
                    end
                    if (cnt_reg == 32'h0) begin
                        if (last) begin
                            state_reg <= mao_pkg::ST_IDLE;
                        end else begin
                            idx_reg    <= idx_reg + 4'h1;
                            data_reg   <= next_chr;
                            strobe_reg <= 1'b1;
                            cnt_reg    <= char_per - 32'h1;
                        end
                    end
                end
                // Word held stable until the link acknowledges it
                mao_pkg::ST_SER: begin
                    ser_char_reg <= mao_char(idx_reg, tx_reading_reg);
                    req_tgl_reg  <= ~req_tgl_reg;
                    state_reg    <= mao_pkg::ST_WAIT;
                end
                mao_pkg::ST_WAIT: begin
                    if (ack_edge) begin
                        idx_reg   <= last ? idx_reg : idx_reg + 4'h1;
                        state_reg <= last ? mao_pkg::ST_IDLE : mao_pkg::ST_SER;
                    end
                end
                default: state_reg <= mao_pkg::ST_IDLE;
            endcase
        end
    end

    // Link domain; its clock must run while a frame is in flight
    logic        lrst_s1_reg, lrst_s2_reg, lstrap_s1_reg, lstrap_s2_reg;
    logic        lreq_s1_reg, lreq_s2_reg, lreq_s3_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic [15:0] baud_cnt_reg;
    logic        line_reg, lbusy_reg;
    wire  [15:0] bit_per  = lstrap_s2_reg ? 16'(FAST_BIT_CYC) : 16'(SLOW_BIT_CYC);
    wire         lreq_new = (lreq_s3_reg != lreq_s2_reg);
    wire         baud_end = (baud_cnt_reg == 16'h0);
    wire         link_hold = rst_in || lrst_s2_reg;

    always_ff @(posedge link_clk_in) begin
        lrst_s1_reg   <= rst_in;
        lrst_s2_reg   <= lrst_s1_reg;
        lstrap_s1_reg <= rate_select_strap_in;
        lstrap_s2_reg <= lstrap_s1_reg;
        lreq_s1_reg   <= req_tgl_reg;
        lreq_s2_reg   <= lreq_s1_reg;
        lreq_s3_reg   <= lreq_s2_reg;
    end

    // idle and stop are mark, current flowing
    // start, seven data LSB first, stop
    always_ff @(posedge link_clk_in) begin
        if (lrst_s2_reg) begin
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 4'h0;
            baud_cnt_reg <= 16'h0;
            line_reg     <= mao_pkg::LINE_MARK;
            lbusy_reg    <= 1'b0;
            ack_tgl_reg  <= 1'b0;
        end else if (!lbusy_reg) begin
            if (lreq_new) begin
                shift_reg    <= {mao_pkg::LINE_MARK, ser_char_reg};
                bit_cnt_reg  <= mao_pkg::FRAME_REST;
                baud_cnt_reg <= bit_per - 16'h1;
                line_reg     <= ~mao_pkg::LINE_MARK;
                lbusy_reg    <= 1'b1;
            end
        end else if (!baud_end) begin
            baud_cnt_reg <= baud_cnt_reg - 16'h1;
        end else if (bit_cnt_reg == 4'h0) begin
            lbusy_reg   <= 1'b0;
            ack_tgl_reg <= ~ack_tgl_reg;
        end else begin
            line_reg     <= shift_reg[0];
            shift_reg    <= {1'b0, shift_reg[7:1]};
            bit_cnt_reg  <= bit_cnt_reg - 4'h1;
            baud_cnt_reg <= bit_per - 16'h1;
        end
    end

    assign char_data_out    = data_reg;
    assign char_strobe_out  = strobe_reg;
    // both serial outputs share one line register
    assign loop_current_out = line_reg;
    assign serial_ttl_out   = line_reg;
    assign busy_out         = !idle;
    assign integrate_out    = integ_reg;
    assign new_data_out     = new_data_reg;
    assign disp_test_out    = disp_test_reg;
    assign disp_reading_out = result_reg;
    // Checking helper: cycles since the last strobe fall
    logic [31:0] fall_gap_reg;
    always_ff @(posedge clock_in) begin
        if (rst_in || (strobe_reg == 1'b0 && $past(strobe_reg))) begin
            fall_gap_reg <= 32'h1;
        end else begin
            fall_gap_reg <= fall_gap_reg + 32'h1;
        end
    end

    AST_NINE_CHARS: assert property (@(posedge clock_in) disable iff (rst_in)
        idx_reg <= mao_pkg::LAST_CHAR) else $error("character index past nine");
    AST_STROBE_FALL: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(char_strobe_out) |-> $stable(char_data_out) && state_reg == mao_pkg::ST_CHAR)
        else $error("strobe fell with data moving");
    AST_DATA_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        $changed(char_data_out) |-> !$past(char_strobe_out) && char_strobe_out)
        else $error("data changed while strobe high");
    AST_CHAR_RATE: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(char_strobe_out) && idx_reg != 4'h0 && $stable(strap_s2_reg)
        |-> fall_gap_reg == char_per) else $error("character period wrong");
    AST_START_BIT: assert property (@(posedge link_clk_in) disable iff (link_hold)
        $rose(lbusy_reg) |-> line_reg == 1'b0 ##1 line_reg == 1'b0)
        else $error("frame without start bit");
    AST_BIT_TIME: assert property (@(posedge link_clk_in) disable iff (link_hold)
        $changed(line_reg) && lbusy_reg && $past(lbusy_reg) |-> $past(baud_end))
        else $error("line moved inside a bit time");
    AST_SAME_STREAM: assert property (@(posedge link_clk_in) disable iff (link_hold)
        serial_ttl_out == loop_current_out) else $error("serial outputs differ");
    AST_OPEN_TC: assert property (@(posedge clock_in) disable iff (rst_in)
        state_reg == mao_pkg::ST_CHAR && tx_reading_reg.open_tc && char_strobe_out
        && idx_reg >= 4'h1 && idx_reg <= 4'h4 |-> char_data_out == mao_pkg::CH_E)
        else $error("open sensor digit not E");
    AST_UPDATE_GAP: assert property (@(posedge clock_in) disable iff (rst_in)
        new_data_out |-> $past(gap_cnt_reg) >= 32'(GAP_CYC - 1))
        else $error("readings updated too close");
    AST_IGNORE_BUSY: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(busy_out) |-> $past(idle) && !$past(test_on)) else $error("start while busy");
    AST_DISPLAY: assert property (@(posedge clock_in) disable iff (rst_in)
        $changed(disp_reading_out) |-> new_data_out) else $error("display moved without data");
    AST_TEST_QUIET: assert property (@(posedge clock_in) disable iff (rst_in)
        disp_test_out |-> idle) else $error("output during display test");
    AST_INTEG: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(integrate_out) |-> integrate_out [*8]) else $error("integration window short");
    CVR_PAR_DONE: cover property (@(posedge clock_in) disable iff (rst_in)
        state_reg == mao_pkg::ST_CHAR && last && cnt_reg == 32'h0);
    CVR_SER_DONE: cover property (@(posedge clock_in) disable iff (rst_in)
        state_reg == mao_pkg::ST_WAIT && last && ack_edge);
    CVR_REQ_BUSY: cover property (@(posedge clock_in) disable iff (rst_in)
        !idle && !req_s2_reg);
    CVR_OPEN_TX: cover property (@(posedge clock_in) disable iff (rst_in)
        req_go && result_reg.open_tc);
endmodule : mao_ascii_out

// ---- mao_pkg.sv ----
// Constants, carrier types and state codes of the meter ASCII output block
package mao_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned LINK_HZ       = 6_250_000;
    localparam int unsigned TEST_S        = 3;
    localparam int unsigned TEST_CYC      = TEST_S * CLK_HZ;
    localparam int unsigned CONV_MS       = 400;
    localparam int unsigned CONV_CYC      = CONV_MS * (CLK_HZ / 1000);
    localparam int unsigned INTEG_MS      = 100;
    localparam int unsigned INTEG_CYC     = INTEG_MS * (CLK_HZ / 1000);
    localparam int unsigned GAP_MS        = 150;
    localparam int unsigned GAP_CYC       = GAP_MS * (CLK_HZ / 1000);
    localparam int unsigned SLOW_CPS      = 25;
    localparam int unsigned FAST_CPS      = 100;
    localparam int unsigned SLOW_CHAR_CYC = CLK_HZ / SLOW_CPS;
    localparam int unsigned FAST_CHAR_CYC = CLK_HZ / FAST_CPS;
    localparam int unsigned SLOW_BAUD     = 300;
    localparam int unsigned FAST_BAUD     = 1200;
    localparam int unsigned SLOW_BIT_CYC  = LINK_HZ / SLOW_BAUD;
    localparam int unsigned FAST_BIT_CYC  = LINK_HZ / FAST_BAUD;
    localparam logic [3:0]  LAST_CHAR     = 4'h8;
    localparam logic [3:0]  FRAME_REST    = 4'h8;
    localparam logic [6:0]  CH_PLUS       = 7'h2B;
    localparam logic [6:0]  CH_MINUS      = 7'h2D;
    localparam logic [6:0]  CH_ZERO       = 7'h30;
    localparam logic [6:0]  CH_E          = 7'h45;
    localparam logic [6:0]  CH_SPACE      = 7'h20;
    localparam logic [6:0]  CH_C          = 7'h43;
    localparam logic [6:0]  CH_F          = 7'h46;
    localparam logic [6:0]  CH_CR         = 7'h0D;
    localparam logic [6:0]  CH_LF         = 7'h0A;
    localparam logic        LINE_MARK     = 1'b1;

    typedef struct packed {
        logic        neg;
        logic        open_tc;
        logic        fahr;
        logic [15:0] bcd;
    } mao_reading_t;

    localparam mao_reading_t READING_RST = '0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHAR = 4'h2,
        ST_SER  = 4'h4,
        ST_WAIT = 4'h8
    } mao_state_t;
endpackage : mao_pkg

// ---- mao_printer_model.sv ----
// Printer-side model: strobe capture and async serial decode
`timescale 1ns/1ps
module mao_printer_model (
    input wire logic       clock_in,
    input wire logic       link_clk_in,
    input wire logic [6:0] char_data_in,
    input wire logic       char_strobe_in,
    input wire logic       line_in,
    input wire logic [7:0] bit_cyc_in
);
    logic [6:0] char_q[$];
    logic [6:0] ser_q[$];
    int         fall_q[$];
    int         cyc = 0;
    int         errs = 0;
    logic [6:0] held;
    logic [6:0] ch;

    always @(posedge clock_in) cyc <= cyc + 1;

    always @(posedge char_strobe_in) begin
        // Data is written on the same edge; let it settle first
        #1;
        held = char_data_in;
    end

    always @(negedge char_strobe_in) begin
        #1;
        if (char_data_in !== held) errs++;
        char_q.push_back(char_data_in);
        fall_q.push_back(cyc);
    end

    // start, seven bits LSB first, stop
    initial forever begin
        @(posedge link_clk_in);
        if (line_in === 1'b0) begin
            // Sample each bit at its middle
            repeat (bit_cyc_in / 2) @(posedge link_clk_in);
            for (int i = 0; i < 7; i++) begin
                repeat (bit_cyc_in) @(posedge link_clk_in);
                ch[i] = line_in;
            end
            repeat (bit_cyc_in) @(posedge link_clk_in);
            if (line_in !== mao_pkg::LINE_MARK) errs++;
            ser_q.push_back(ch);
        end
    end
endmodule : mao_printer_model

// ---- tb_top.sv ----
// Self-checking bench for the meter ASCII output block
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned CONV_CYC = 400;
    localparam int unsigned TEST_CYC = 200;
    localparam int unsigned INTEG_CYC = 100;
    localparam int unsigned GAP_CYC = 150;

    logic                  clock_in = 1'b0;
    logic                  link_clk_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic                  strap = 1'b1;
    logic                  request_n = 1'b1;
    logic                  trig = 1'b1;
    logic [7:0]            bit_cyc = 8'h08;
    mao_pkg::mao_reading_t reading = '0;
    logic [6:0]            char_data;
    logic                  strobe, loop_cur, ser_ttl, busy, integ, new_data, disp_test;
    mao_pkg::mao_reading_t disp_reading, prev_disp;
    int                    mismatches = 0;
    int                    n_compared = 0;
    int                    gap = 150;
    int                    run = 0;

    always #5 clock_in = ~clock_in;
    // Link clock free-running, phase unrelated
    initial #3 forever #80 link_clk_in = ~link_clk_in;

    mao_ascii_out #(.TEST_CYC(TEST_CYC), .CONV_CYC(CONV_CYC), .INTEG_CYC(INTEG_CYC),
        .GAP_CYC(GAP_CYC), .SLOW_CHAR_CYC(80), .FAST_CHAR_CYC(40), .SLOW_BIT_CYC(24),
        .FAST_BIT_CYC(8)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
        .rate_select_strap_in(strap), .request_n_in(request_n), .serial_trig_in(trig),
        .reading_in(reading), .char_data_out(char_data), .char_strobe_out(strobe),
        .loop_current_out(loop_cur), .serial_ttl_out(ser_ttl), .busy_out(busy),
        .integrate_out(integ), .new_data_out(new_data), .disp_test_out(disp_test),
        .disp_reading_out(disp_reading));

    mao_printer_model i_printer (.clock_in(clock_in), .link_clk_in(link_clk_in),
        .char_data_in(char_data), .char_strobe_in(strobe), .line_in(loop_cur),
        .bit_cyc_in(bit_cyc));

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp_num

    task automatic cmp_char(input logic [6:0] got, input logic [6:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp_char

    // Bounded wait on busy (which 0) or new data (which 1)
    task automatic wait_sig(input logic which, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clock_in);
            #1;
            if ((which ? new_data : busy) === lvl) return;
        end
        mismatches++;
        conclude();
    endtask : wait_sig

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clock_in);
            #1;
            seen = seen | busy;
        end
        cmp_num(seen, 1'b0);
        @(posedge clock_in);
    endtask : quiet

    function automatic logic [6:0] exp_char(input mao_pkg::mao_reading_t r, input int k);
        logic [3:0] d;
        d = r.bcd[15 - 4 * ((k - 1) & 3) -: 4];
        case (k)
            0: return (r.neg && !r.open_tc) ? mao_pkg::CH_MINUS : mao_pkg::CH_PLUS;
            1, 2, 3, 4: return r.open_tc ? mao_pkg::CH_E : mao_pkg::CH_ZERO + {3'h0, d};
            5: return mao_pkg::CH_SPACE;
            6: return r.fahr ? mao_pkg::CH_F : mao_pkg::CH_C;
            7: return mao_pkg::CH_CR;
            default: return mao_pkg::CH_LF;
        endcase
    endfunction : exp_char

    // Two updates so the new reading is surely latched
    task automatic setup(input logic s, input mao_pkg::mao_reading_t r);
        @(posedge clock_in);
        strap <= s;
        reading <= r;
        wait_sig(1'b1, 1'b1, 2 * CONV_CYC);
        @(posedge clock_in);
        wait_sig(1'b1, 1'b1, 2 * CONV_CYC);
        cmp_num(disp_reading, r); // latched reading shown
        i_printer.char_q.delete();
        i_printer.ser_q.delete();
        i_printer.fall_q.delete();
        i_printer.errs = 0;
        @(posedge clock_in);
    endtask : setup

    task automatic sc_reset;
        int n;
        repeat (2) @(posedge clock_in);
        cmp_num({disp_test, busy, strobe}, 3'h4); // reset state
        // Request and trigger edge during the display test
        request_n <= 1'b0;
        trig <= 1'b0;
        repeat (48) @(posedge clock_in);
        rst_in <= 1'b0;
        n = 0;
        while (disp_test !== 1'b0 && n < 1000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        cmp_num(n > TEST_CYC - 3 && n < TEST_CYC + 3, 1'b1);
        quiet(60);
        request_n <= 1'b1;
        trig <= 1'b1;
        quiet(10); // rising edge starts nothing
    endtask : sc_reset

    task automatic sc_char(input logic s, input mao_pkg::mao_reading_t r, input int p);
        setup(s, r);
        request_n <= 1'b0;
        wait_sig(1'b0, 1'b1, 10);
        // Release and pull low again mid-transmission
        repeat (3 * p) @(posedge clock_in);
        request_n <= 1'b1;
        repeat (4) @(posedge clock_in);
        request_n <= 1'b0;
        wait_sig(1'b0, 1'b0, 10 * p);
        quiet(2 * p);
        request_n <= 1'b1;
        cmp_num(i_printer.char_q.size(), 9);
        for (int k = 0; k < 9; k++) cmp_char(i_printer.char_q[k], exp_char(r, k));
        for (int k = 1; k < 9; k++) cmp_num(i_printer.fall_q[k] - i_printer.fall_q[k - 1], p);
        cmp_num(i_printer.errs, 0);
    endtask : sc_char

    task automatic sc_serial(input logic s, input mao_pkg::mao_reading_t r, input int b);
        bit_cyc = 8'(b);
        setup(s, r);
        cmp_num(loop_cur, mao_pkg::LINE_MARK);
        trig <= 1'b0;
        wait_sig(1'b0, 1'b1, 10);
        repeat (200) @(posedge clock_in);
        trig <= 1'b1;
        repeat (200) @(posedge clock_in);
        trig <= 1'b0;
        wait_sig(1'b0, 1'b0, 2000 * b);
        quiet(320 * b);
        trig <= 1'b1;
        cmp_num(i_printer.ser_q.size(), 9);
        for (int k = 0; k < 9; k++) cmp_char(i_printer.ser_q[k], exp_char(r, k));
        cmp_num(i_printer.errs, 0);
    endtask : sc_serial

    always @(negedge clock_in) begin
        if (!rst_in) begin
            if (disp_reading !== prev_disp) cmp_num(new_data, 1'b1);
            if (new_data === 1'b1) begin
                cmp_num(gap >= GAP_CYC, 1'b1);
                gap = 0;
            end
            if (integ === 1'b1) run++;
            else if (run > 0) begin
                cmp_num(run, INTEG_CYC);
                run = 0;
            end
            gap++;
        end
        prev_disp = disp_reading;
    end

    always @(posedge link_clk_in) if (!rst_in) cmp_num(ser_ttl, loop_cur);

    initial begin
        sc_reset();
        sc_char(1'b1, '{1'b0, 1'b0, 1'b0, 16'h1234}, 40);
        sc_char(1'b0, '{1'b1, 1'b1, 1'b1, 16'h0567}, 80);
        sc_char(1'b1, '{1'b1, 1'b0, 1'b1, 16'h0987}, 40);
        sc_serial(1'b1, '{1'b1, 1'b0, 1'b0, 16'h1905}, 8);
        sc_serial(1'b0, '{1'b0, 1'b1, 1'b0, 16'h0000}, 24);
        conclude();
    end
endmodule : tb_top
